// file: verilog/otc_trim_ctrl.v
`timescale 1ns/10ps
// Operation
// - the six-bit analog trim gives 32 minus the code in ppm, one ppm per step.
// - the analog trim comes from factory storage at power-up and writes never change it.
// - the initial trim register carries digital trim in bits 7:6 and analog trim in bits 5:0.
// - the curvature register holds the absolute coefficient times 2048 in bits 6:0.
// - the curvature value is reloaded at power-up and software writes to it are ignored.
// - a write to the gain register changes only the three upper enable bits.
// - with sensing on and on main supply, sensor and converter run and final trims follow the results.
// - the sensing enable reads zero after power-up so sensing starts off.
// - with sensing off on main supply, the oscillator is steered by the initial trims.
// - setting the sensing enable on main supply starts two conversions whose average is stored.
// - the battery sensing enable defaults to zero and allows battery compensation when one.
// - battery compensation is suppressed while the battery is below threshold.
// - on battery the rate bit picks ten minutes when zero and one minute when one.
`include "otc_defines.vh"
module otc_trim_ctrl #(
  parameter SEC_CYCLES  = `OTC_SEC_CYCLES,
  parameter CONV_CYCLES = `OTC_CONV_CYCLES
) (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire [7:0]  fuse_init_trim,
  input  wire [7:0]  fuse_curve,
  input  wire [4:0]  fuse_gain,
  input  wire        on_battery,
  input  wire        battery_low,
  output reg         sensor_on,
  output reg         conv_start,
  input  wire        conv_done,
  input  wire [9:0]  conv_value,
  input  wire [5:0]  comp_analog,
  input  wire [4:0]  comp_digital,
  output reg  [5:0]  final_analog_trim,
  output reg  [4:0]  final_digital_trim,
  output reg  [6:0]  analog_ppm,
  output reg  [9:0]  temp_result
);
  localparam ST_IDLE  = 4'b0001;
  localparam ST_CONV1 = 4'b0010;
  localparam ST_CONV2 = 4'b0100;
  localparam ST_APPLY = 4'b1000;
  // interval kept in seconds so the divider never needs a minute-sized count
  localparam [9:0] PER_SHORT = `OTC_MIN_SHORT * `OTC_SEC_PER_MIN;
  localparam [9:0] PER_LONG  = `OTC_MIN_LONG * `OTC_SEC_PER_MIN;

  reg [1:0]  load_r;
  reg [7:0]  init_trim_r;
  reg [6:0]  curve_r;
  reg [4:0]  gain_r;
  reg        temp_sense_enable_r;
  reg        battery_sense_enable_r;
  reg        battery_sense_rate_r;
  reg [3:0]  state_r;
  reg [3:0]  state_nxt;
  reg [9:0]  first_r;
  reg [9:0]  min_cnt_r;
  reg [31:0] conv_cnt_r;
  reg        tse_d_r;
  wire       sec_tick;
  wire       wr_en;
  wire       rd_en;
  wire       batt_comp_ok;
  wire       vdd_comp_ok;
  wire       comp_ok;
  wire       start_req;
  wire [9:0] period_min;
  wire [10:0] sum;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;

  // strap capture after release, never on reset itself
  // fuse load once
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      load_r      <= 2'h0;
      init_trim_r <= 8'h00;
      curve_r     <= 7'h00;
      gain_r      <= 5'h00;
    end else if (load_r != 2'h3) begin
      load_r <= load_r + 2'h1;
      if (load_r == 2'h0) begin
        init_trim_r <= fuse_init_trim;
        curve_r     <= fuse_curve[6:0];
        gain_r      <= fuse_gain;
      end
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      temp_sense_enable_r    <= 1'b0;
      battery_sense_enable_r <= 1'b0;
      battery_sense_rate_r   <= 1'b0;
    end else if (wr_en && paddr == `OTC_OFF_SENSE_GAIN) begin
      temp_sense_enable_r    <= pwdata[`OTC_BIT_TSE];
      battery_sense_enable_r <= pwdata[`OTC_BIT_BATTERY_SENSE_ENABLE];
      battery_sense_rate_r   <= pwdata[`OTC_BIT_BATTERY_SENSE_RATE];
    end
  end

  assign batt_comp_ok = on_battery & battery_sense_enable_r & ~battery_low;
  assign vdd_comp_ok  = ~on_battery & temp_sense_enable_r;
  assign comp_ok      = batt_comp_ok | vdd_comp_ok;

  assign period_min = battery_sense_rate_r ? PER_SHORT : PER_LONG;

  otc_tick_div #(
    .DIV(SEC_CYCLES)
  ) u_min_div (
    .sys_clk(sys_clk),
    .reset  (reset),
    .run    (batt_comp_ok),
    .tick   (sec_tick)
  );

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      min_cnt_r <= 10'h000;
      tse_d_r   <= 1'b0;
    end else begin
      tse_d_r <= temp_sense_enable_r;
      if (!batt_comp_ok || state_r != ST_IDLE && sec_tick && min_cnt_r + 10'h001 >= period_min)
        min_cnt_r <= 10'h000;
      else if (sec_tick)
        min_cnt_r <= (min_cnt_r + 10'h001 >= period_min) ? 10'h000 : min_cnt_r + 10'h001;
    end
  end

  assign start_req = (vdd_comp_ok & temp_sense_enable_r & ~tse_d_r)
                   | (batt_comp_ok & sec_tick & (min_cnt_r + 10'h001 >= period_min));
  assign sum = {1'b0, first_r} + {1'b0, conv_value};

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (start_req) state_nxt = ST_CONV1;
      ST_CONV1: if (!comp_ok) state_nxt = ST_IDLE;
                else if (conv_done) state_nxt = ST_CONV2;
      ST_CONV2: if (!comp_ok) state_nxt = ST_IDLE;
                else if (conv_done) state_nxt = ST_APPLY;
      ST_APPLY: state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r     <= ST_IDLE;
      first_r     <= 10'h000;
      temp_result <= 10'h000;
      conv_start  <= 1'b0;
      sensor_on   <= 1'b0;
      conv_cnt_r  <= 32'h00000000;
    end else begin
      state_r    <= state_nxt;
      conv_start <= (state_r == ST_IDLE && state_nxt == ST_CONV1) ||
                    (state_r == ST_CONV1 && state_nxt == ST_CONV2);
      sensor_on  <= (state_nxt == ST_CONV1) || (state_nxt == ST_CONV2);
      conv_cnt_r <= (state_nxt == ST_IDLE) ? 32'h00000000 : conv_cnt_r + 32'h00000001;
      if (state_r == ST_CONV1 && conv_done)
        first_r <= conv_value;
      if (state_r == ST_CONV2 && conv_done)
        temp_result <= sum[10:1];
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      final_analog_trim  <= `OTC_ANALOG_MID;
      final_digital_trim <= 5'h00;
    end else if (!comp_ok) begin
      final_analog_trim  <= init_trim_r[5:0];
      final_digital_trim <= {3'h0, init_trim_r[7:6]};
    end else if (state_r == ST_APPLY) begin
      final_analog_trim  <= comp_analog;
      final_digital_trim <= comp_digital;
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset)
      analog_ppm <= 7'h00;
    else
      analog_ppm <= 7'h20 - {1'b0, final_analog_trim};
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr)
        `OTC_OFF_INIT_TRIM:     prdata <= {24'h000000, init_trim_r};
        `OTC_OFF_CURVE:         prdata <= {25'h0000000, curve_r};
        `OTC_OFF_SENSE_GAIN:    prdata <= {24'h000000, temp_sense_enable_r, battery_sense_enable_r,
                                           battery_sense_rate_r, gain_r};
        `OTC_OFF_FINAL_ANALOG:  prdata <= {26'h0000000, final_analog_trim};
        `OTC_OFF_FINAL_DIGITAL: prdata <= {27'h0000000, final_digital_trim};
        `OTC_OFF_TEMP_RESULT:   prdata <= {22'h000000, temp_result};
        `OTC_OFF_STATUS:        prdata <= {27'h0000000, comp_ok, state_r};
        default:                prdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// file: verilog/otc_defines.vh
`ifndef OTC_DEFINES_VH
`define OTC_DEFINES_VH
`define OTC_OFF_INIT_TRIM     32'h0000002C
`define OTC_OFF_CURVE         32'h00000030
`define OTC_OFF_SENSE_GAIN    32'h00000034
`define OTC_OFF_FINAL_ANALOG  32'h00000038
`define OTC_OFF_FINAL_DIGITAL 32'h0000003C
`define OTC_OFF_TEMP_RESULT   32'h00000040
`define OTC_OFF_STATUS        32'h00000044
`define OTC_IDX_INIT_TRIM     8'h0B
`define OTC_IDX_CURVE         8'h0C
`define OTC_IDX_SENSE_GAIN    8'h0D
`define OTC_IDX_FINAL_ANALOG  8'h0E
`define OTC_IDX_FINAL_DIGITAL 8'h0F
`define OTC_BIT_TSE           7
`define OTC_BIT_BATTERY_SENSE_ENABLE          6
`define OTC_BIT_BATTERY_SENSE_RATE          5
`define OTC_ANALOG_MID        6'h20
`define OTC_SCALE_COEFF       2048
`define OTC_MIN_SHORT         1
`define OTC_MIN_LONG          10
`define OTC_SEC_PER_MIN       60
`define OTC_CONV_COUNT        2
`define OTC_CONV_MS           22
`define OTC_CLK_MHZ           250
`define OTC_SEC_CYCLES        (`OTC_CLK_MHZ * 1000000)
`define OTC_CONV_CYCLES       (`OTC_CONV_MS * `OTC_CLK_MHZ * 1000)
`endif

// file: verilog/otc_tick_div.v
`timescale 1ns/10ps
module otc_tick_div #(
  parameter DIV = 250000000
) (
  input  wire sys_clk,
  input  wire reset,
  input  wire run,
  output reg  tick
);
  reg [31:0] cnt_r;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 32'h00000000;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_r <= 32'h00000000;
      tick  <= 1'b0;
    end else if (cnt_r == DIV - 1) begin
      cnt_r <= 32'h00000000;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h00000001;
      tick  <= 1'b0;
    end
  end
endmodule

// file: tb/otc_trim_ctrl_assertions.sv
`timescale 1ns/10ps
module otc_trim_ctrl_assertions (
  input wire        sys_clk,
  input wire        reset,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire [7:0]  fuse_init_trim,
  input wire [7:0]  fuse_curve,
  input wire [4:0]  fuse_gain,
  input wire        on_battery,
  input wire        battery_low,
  input wire        sensor_on,
  input wire        conv_start,
  input wire [5:0]  final_analog_trim
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence rd(a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  // only a rising enable starts a cycle, so the bench writes it from zero
  sequence wr_tse;
    psel && penable && pwrite && paddr == 32'h34 && pwdata[7] && !on_battery;
  endsequence
  a_init_read:
    assert property (rd(32'h2C) |=> prdata == {24'h0, fuse_init_trim}) else $error("initial trim read");
  a_curve_read:
    assert property (rd(32'h30) |=> prdata[6:0] == fuse_curve[6:0]) else $error("curvature read");
  a_gain_keep:
    assert property (rd(32'h34) |=> prdata[4:0] == fuse_gain) else $error("gain bits changed");
  a_reset_idle:
    assert property ($fell(reset) |-> !sensor_on [*3]) else $error("sensing on after reset");
  a_tse_start:
    assert property (wr_tse |-> ##[1:3] conv_start) else $error("no conversion after enable");
  a_start_pulse:
    assert property (conv_start |=> !conv_start) else $error("start pulse too long");
  a_low_no_conv:
    assert property (on_battery && battery_low |-> !conv_start) else $error("conversion on low battery");
  a_low_revert:
    assert property ($rose(on_battery && battery_low) |-> ##[1:3] final_analog_trim == fuse_init_trim[5:0])
      else $error("trim not restored");
endmodule
bind otc_trim_ctrl otc_trim_ctrl_assertions u_chk (.sys_clk(sys_clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .fuse_init_trim(fuse_init_trim), .fuse_curve(fuse_curve), .fuse_gain(fuse_gain), .on_battery(on_battery),
  .battery_low(battery_low), .sensor_on(sensor_on), .conv_start(conv_start),
  .final_analog_trim(final_analog_trim));

// file: tb/otc_trim_ctrl_tb_top.sv
`timescale 1ns/10ps
module otc_trim_ctrl_tb_top;
  logic        sys_clk = '0, reset = '1, psel = '0, penable = '0, pwrite = '0, conv_done = '0;
  logic        on_battery = '0, battery_low = '0;
  logic [31:0] paddr = '0, pwdata = '0;
  logic [9:0]  conv_value = '0;
  logic [7:0]  trim = 8'h5A;
  logic [5:0]  cd [4] = '{6'h00, 6'h20, 6'h3F, 6'h1A};
  logic [6:0]  pp [4] = '{7'h20, 7'h00, 7'h61, 7'h06};
  wire         pready, pslverr, sensor_on, conv_start;
  wire [31:0]  prdata;
  wire [5:0]   fat;
  wire [4:0]   fdt;
  wire [6:0]   ppm;
  wire [9:0]   temp;
  int          fails = 0, n_compared = 0, gap = 0, big = 0, i;
  // short second so a minute is 600 cycles
  otc_trim_ctrl #(.SEC_CYCLES(10)) dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .fuse_init_trim(trim), .fuse_curve(8'h46), .fuse_gain(5'h13), .on_battery(on_battery),
    .battery_low(battery_low), .sensor_on(sensor_on), .conv_start(conv_start), .conv_done(conv_done),
    .conv_value(conv_value), .comp_analog(6'h11), .comp_digital(5'h03), .final_analog_trim(fat),
    .final_digital_trim(fdt), .analog_ppm(ppm), .temp_result(temp));
  always #2 sys_clk = ~sys_clk;
  // start-to-start spacing; short gaps inside one cycle are ignored
  always @(negedge sys_clk) begin
    if (conv_start === 1'h1) begin
      if (gap > 50) big = gap;
      gap = 0;
    end else gap++;
  end
  task chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, d);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    while (pready !== 1'h1) @(posedge sys_clk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // read data is registered at the access edge, so look after it lands
  task rdchk(input string n, input logic [31:0] a, e);
    apb(1'h0, a, 32'h0);
    @(negedge sys_clk);
    chk(n, e, prdata);
  endtask
  task serve(input logic [9:0] v);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (conv_start !== 1'h1 && k < 7000);
    @(posedge sys_clk);
    conv_done <= 1'h1;
    conv_value <= v;
    @(posedge sys_clk);
    conv_done <= 1'h0;
    if (k >= 7000) chk("conv start", 1, 0);
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    results;
  end
  initial begin
    for (i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      reset <= 1'h1;
      trim <= {2'h1, cd[i]};
      repeat (2) @(posedge sys_clk);
      reset <= 1'h0;
      repeat (4) @(negedge sys_clk);
      chk("ppm", pp[i], ppm);
      chk("final analog", cd[i], fat);
    end
    rdchk("init trim", 32'h2C, 32'h5A);
    rdchk("curve", 32'h30, 32'h46);
    rdchk("sense gain", 32'h34, 32'h13);
    rdchk("unmapped", 32'h48, 32'h0);
    chk("slave error", 32'h0, pslverr);
    $display("test reset values done");
    apb(1'h1, 32'h2C, 32'hFF);
    apb(1'h1, 32'h30, 32'hFF);
    apb(1'h1, 32'h34, 32'h7F);
    rdchk("init trim", 32'h2C, 32'h5A);
    rdchk("curve", 32'h30, 32'h46);
    rdchk("sense gain", 32'h34, 32'h73);
    $display("test write protect done");
    apb(1'h1, 32'h34, 32'h80);
    serve(10'h100);
    serve(10'h203);
    repeat (6) @(negedge sys_clk);
    chk("temp", 32'h181, temp);
    chk("final analog", 32'h11, fat);
    chk("final digital", 32'h3, fdt);
    rdchk("final analog reg", 32'h38, 32'h11);
    rdchk("temp reg", 32'h40, 32'h181);
    $display("test conversion done");
    apb(1'h1, 32'h34, 32'h60);
    on_battery <= 1'h1;
    battery_low <= 1'h1;
    repeat (1300) @(negedge sys_clk);
    chk("final analog", 32'h1A, fat);
    chk("quiet", 1, gap > 1200);
    @(posedge sys_clk);
    battery_low <= 1'h0;
    repeat (4) serve(10'h0C0);
    // gap runs from the second start of one cycle to the first of the next: period minus three
    chk("one minute", 32'd597, big);
    apb(1'h1, 32'h34, 32'h40);
    repeat (4) serve(10'h0C0);
    chk("ten minutes", 32'd5997, big);
    apb(1'h1, 32'h34, 32'h20);
    repeat (1300) @(negedge sys_clk);
    chk("quiet", 1, gap > 1200);
    $display("test battery done");
    results;
  end
endmodule
